// ==== rtl/adc_seq_cfg.svh ====
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Register byte addresses
`define ADDR_CTRL_ONE    4'h0
`define ADDR_CTRL_TWO    4'h4
`define ADDR_CTRL_THREE  4'h8
`define ADDR_CHAN_SEL    4'hC
`define ADDR_SCAN_SEL    5'h10
`define ADDR_STATUS      5'h14

// Control one fields
`define C1_ON       15
`define C1_IDLE     13
`define C1_FMT_HI   9
`define C1_FMT_LO   8
`define C1_TRG_HI   7
`define C1_TRG_LO   5
`define C1_AUTO_SAMPLE_START     2
`define C1_SAMPLE_ACTIVE     1
`define C1_DONE     0
`define C1_WMASK    16'hA3E7

// Control two fields
`define C2_REF_HI   15
`define C2_REF_LO   13
`define C2_SCAN     10
`define C2_BUFFER_FILL_STATUS     7
`define C2_RATE_HI  5
`define C2_RATE_LO  2
`define C2_SPLIT    1
`define C2_ALT      0
`define C2_WMASK    16'hE43F

// Control three fields
`define C3_RC       15
`define C3_AUTO_SAMPLE_TIME_HI  12
`define C3_AUTO_SAMPLE_TIME_LO  8
`define C3_WMASK    16'h9FFF

// Channel select fields
`define CS_WMASK    16'h9F9F

// Codes
`define TRG_MANUAL  3'h0
`define TRG_EXT0    3'h1
`define TRG_TMR3    3'h2
`define TRG_TMR5    3'h4
`define TRG_CHARGE_TIME_UNIT    3'h6
`define TRG_AUTO    3'h7
`define CONVERSION_CLOCK_DIVIDER_MAX    8'h3F
`define POS_MAX     5'h11

`endif

// ==== rtl/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;
  typedef enum logic [1:0] {FMT_INT, FMT_SINT, FMT_FRAC, FMT_SFRAC} format_t;
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_WRITE} seq_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

// ==== rtl/result_memory.sv ====
`timescale 1ns/1ns
`default_nettype none
module result_memory #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2)
  begin : bad_depth
    $error("DEPTH too small");
  end

  always_ff @(posedge clk)
  begin
    if (wrEn) mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule : result_memory
`default_nettype wire

// ==== rtl/adc_sequencing_control.sv ====
// Operation
// - Converter runs only while converter_on set
// - Results lost when converter_on cleared
// - idle_halt stops converter during Idle
// - result_format selects three alignments (both fractional codes alike)
// - Code 111 auto-converts after sample time
// - Code 000 converts when sample_active cleared
// - Ext0, timer3, timer5, charge-unit triggers
// - auto_sample_start restarts sampling after conversion
// - sample_active high while acquiring input
// - Done bit set on completed conversion
// - reference_config selects reference pair
// - Scan steps MUX A positive input
// - Fill status shows half being filled
// - Interrupt every rate-plus-one sequences
// - Split mode uses two 8-word halves
// - Alternate mode swaps MUX A and B
// - rc_clock_select picks RC conversion clock
// - Divider sets conversion clock period
// - Negative select picks input 1 or ref
// - Positive select picks input or bandgap
// - Scan visits only selected channels
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequencing_control #(
  parameter int CONV_PERIODS = 12,
  parameter int BUF_DEPTH    = 16
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite slave
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Device side
  input  wire logic        idleMode,
  input  wire logic        rcClockTick,
  input  wire logic        externalInterruptZero,
  input  wire logic        timer3Compare,
  input  wire logic        timer5Compare,
  input  wire logic        chargeTimeUnitEvent,
  input  wire logic [9:0]  conversionData,
  input  wire logic [3:0]  resultIndex,
  output logic [15:0]      resultData,
  output logic             converterActive,
  output logic             sampleHold,
  output logic             convertStart,
  output logic [4:0]       positiveInputSel,
  output logic             negativeInputAlt,
  output logic [1:0]       referenceSelect,
  output logic             convDoneEvent,
  output logic             sequenceInterrupt
);
  import adc_seq_pkg::*;

  if (BUF_DEPTH != 16)
  begin : bad_depth
    $error("BUF_DEPTH must be 16");
  end
  if (CONV_PERIODS < 1 || CONV_PERIODS > 255)
  begin : bad_periods
    $error("CONV_PERIODS out of range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ctrlOne_reg, ctrlTwo_reg, ctrlThree_reg, chanSel_reg, scanSel_reg;
  logic        sample_active_reg, done_reg, buffer_fill_status_reg, ext0Prev_reg;
  seq_state_t  state_reg;
  logic [7:0]  divCnt_reg;
  logic [7:0]  tadCnt_reg;
  logic [3:0]  wrPtr_reg, seqCnt_reg, scanIdx_reg;
  logic        altB_reg;
  logic        awPend_reg, wPend_reg;
  logic [4:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] st, input logic [15:0] m);
    logic [15:0] n;
    n = old;
    if (st[0]) n[7:0] = d[7:0];
    if (st[1]) n[15:8] = d[15:8];
    return (n & m) | (old & ~m);
  endfunction : merge

  // ----------------------------------------
  // AXI write path
  // ----------------------------------------
  logic doWrite;
  assign s_axi_awready = !awPend_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wPend_reg && !s_axi_bvalid;
  assign doWrite       = awPend_reg && wPend_reg;
  assign s_axi_bresp   = 2'h0;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awPend_reg   <= 1'b0;
      wPend_reg    <= 1'b0;
      awAddr_reg   <= 5'h0;
      wData_reg    <= 32'h0;
      wStrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awPend_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wPend_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awPend_reg   <= 1'b0;
        wPend_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer decode
  // ----------------------------------------
  logic       running, tadTick, trigger, convEnd, wrSamp, wrDone;
  logic [2:0] trg;
  logic       ctrlOneWr, turnOn;
  assign ctrlOneWr = doWrite && awAddr_reg == {1'b0, `ADDR_CTRL_ONE} && wStrb_reg[0];
  // Software may switch on and start sampling in one write
  assign turnOn    = doWrite && awAddr_reg == {1'b0, `ADDR_CTRL_ONE} && wStrb_reg[1] && wData_reg[`C1_ON];
  assign running   = ctrlOne_reg[`C1_ON] && !(ctrlOne_reg[`C1_IDLE] && idleMode);
  assign trg       = ctrlOne_reg[`C1_TRG_HI:`C1_TRG_LO];
  assign wrSamp    = wData_reg[`C1_SAMPLE_ACTIVE];
  assign wrDone    = wData_reg[`C1_DONE];
  assign tadTick   = ctrlThree_reg[`C3_RC] ? rcClockTick : (divCnt_reg == 8'h0);

  always_comb
  begin
    case (trg)
      `TRG_MANUAL: trigger = ctrlOneWr && sample_active_reg && !wrSamp;
      `TRG_EXT0:   trigger = externalInterruptZero && !ext0Prev_reg;
      `TRG_TMR3:   trigger = timer3Compare;
      `TRG_TMR5:   trigger = timer5Compare;
      `TRG_CHARGE_TIME_UNIT:   trigger = chargeTimeUnitEvent;
      `TRG_AUTO:   trigger = tadTick && tadCnt_reg >= {3'h0, ctrlThree_reg[`C3_AUTO_SAMPLE_TIME_HI:`C3_AUTO_SAMPLE_TIME_LO]};
      default:     trigger = 1'b0;
    endcase
  end

  assign convEnd      = state_reg == ST_CONVERT && tadTick && tadCnt_reg == 8'(CONV_PERIODS - 1);
  assign convertStart = state_reg == ST_SAMPLE && trigger && running;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst) divCnt_reg <= 8'h0;
    else if (divCnt_reg == 8'h0 || !running) divCnt_reg <= ctrlThree_reg[7:0];
    else divCnt_reg <= divCnt_reg - 8'h1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst) ext0Prev_reg <= 1'b0;
    else ext0Prev_reg <= externalInterruptZero;
  end

  // ----------------------------------------
  // State machine and status bits
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg  <= ST_IDLE;
      tadCnt_reg <= 8'h0;
    end
    else if (!running) state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          tadCnt_reg <= 8'h0;
          if (sample_active_reg) state_reg <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          if (trigger)
          begin
            state_reg  <= ST_CONVERT;
            tadCnt_reg <= 8'h0;
          end
          else if (!sample_active_reg) state_reg <= ST_IDLE;
          else if (tadTick && tadCnt_reg != 8'hFF) tadCnt_reg <= tadCnt_reg + 8'h1;
        end
        ST_CONVERT:
        begin
          if (convEnd) state_reg <= ST_WRITE;
          else if (tadTick) tadCnt_reg <= tadCnt_reg + 8'h1;
        end
        ST_WRITE:
        begin
          tadCnt_reg <= 8'h0;
          state_reg  <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Hardware set wins over software write in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_active_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      if (!ctrlOne_reg[`C1_ON] && !turnOn) sample_active_reg <= 1'b0;
      else if (state_reg == ST_WRITE && ctrlOne_reg[`C1_AUTO_SAMPLE_START]) sample_active_reg <= 1'b1;
      else if (convertStart) sample_active_reg <= 1'b0;
      else if (ctrlOneWr) sample_active_reg <= wrSamp;
      if (state_reg == ST_WRITE) done_reg <= 1'b1;
      else if (convertStart) done_reg <= 1'b0;
      else if (ctrlOneWr) done_reg <= wrDone;
    end
  end

  // ----------------------------------------
  // Input selection
  // ----------------------------------------
  function automatic logic [3:0] nextScan(input logic [3:0] cur, input logic [15:0] sel);
    logic [3:0] idx;
    logic       found;
    idx   = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      if (!found && sel[4'(cur + 4'(i))])
      begin
        idx   = 4'(cur + 4'(i));
        found = 1'b1;
      end
    end
    return idx;
  endfunction : nextScan

  logic useB;
  assign useB             = ctrlTwo_reg[`C2_ALT] && altB_reg;
  assign positiveInputSel = useB ? chanSel_reg[12:8]
                          : (ctrlTwo_reg[`C2_SCAN] ? {1'b0, scanIdx_reg} : chanSel_reg[4:0]);
  assign negativeInputAlt = useB ? chanSel_reg[15] : chanSel_reg[7];
  always_comb
  begin
    case (ctrlTwo_reg[`C2_REF_HI:`C2_REF_LO])
      3'h1:    referenceSelect = 2'h1;
      3'h2:    referenceSelect = 2'h2;
      3'h3:    referenceSelect = 2'h3;
      default: referenceSelect = 2'h0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      altB_reg    <= 1'b0;
      scanIdx_reg <= 4'h0;
    end
    else if (!ctrlOne_reg[`C1_ON])
    begin
      altB_reg    <= 1'b0;
      scanIdx_reg <= nextScan(4'hF, scanSel_reg);
    end
    else if (state_reg == ST_WRITE)
    begin
      altB_reg <= ctrlTwo_reg[`C2_ALT] && !altB_reg;
      if (!useB) scanIdx_reg <= nextScan(scanIdx_reg, scanSel_reg);
    end
  end

  // ----------------------------------------
  // Result storage and interrupt rate
  // ----------------------------------------
  logic [15:0] formatted;
  logic        seqWrap;
  always_comb
  begin
    case (format_t'(ctrlOne_reg[`C1_FMT_HI:`C1_FMT_LO]))
      FMT_SFRAC: formatted = {conversionData, 6'h0};
      FMT_FRAC:  formatted = {conversionData, 6'h0};
      FMT_SINT:  formatted = {{6{conversionData[9]}}, conversionData};
      default:   formatted = {6'h0, conversionData};
    endcase
  end

  assign seqWrap           = seqCnt_reg == ctrlTwo_reg[`C2_RATE_HI:`C2_RATE_LO];
  assign convDoneEvent     = state_reg == ST_WRITE;
  assign sequenceInterrupt = convDoneEvent && seqWrap;
  assign converterActive   = running;
  assign sampleHold        = sample_active_reg && running;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_reg  <= 4'h0;
      seqCnt_reg <= 4'h0;
      buffer_fill_status_reg   <= 1'b0;
    end
    else if (!ctrlOne_reg[`C1_ON])
    begin
      wrPtr_reg  <= 4'h0;
      seqCnt_reg <= 4'h0;
      buffer_fill_status_reg   <= 1'b0;
    end
    else if (convDoneEvent)
    begin
      if (seqWrap)
      begin
        seqCnt_reg <= 4'h0;
        // Split mode swaps halves each interrupt
        buffer_fill_status_reg   <= ctrlTwo_reg[`C2_SPLIT] && !buffer_fill_status_reg;
        wrPtr_reg  <= (ctrlTwo_reg[`C2_SPLIT] && !buffer_fill_status_reg) ? 4'h8 : 4'h0;
      end
      else
      begin
        seqCnt_reg <= seqCnt_reg + 4'h1;
        wrPtr_reg  <= wrPtr_reg + 4'h1;
      end
    end
  end

  // Off clears contents by masking reads; permits losing the data
  logic [15:0] memData;
  result_memory #(.DEPTH(BUF_DEPTH), .WIDTH(16)) result_memory_inst (
    .clk    (clk),
    .wrEn   (convDoneEvent),
    .wrAddr (wrPtr_reg),
    .wrData (formatted),
    .rdAddr (resultIndex),
    .rdData (memData)
  );
  assign resultData = ctrlOne_reg[`C1_ON] ? memData : 16'h0;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrlOne_reg   <= 16'h0;
      ctrlTwo_reg   <= 16'h0;
      ctrlThree_reg <= 16'h0;
      chanSel_reg   <= 16'h0;
      scanSel_reg   <= 16'h0;
    end
    else if (doWrite)
    begin
      case (awAddr_reg)
        {1'b0, `ADDR_CTRL_ONE}:   ctrlOne_reg   <= merge(ctrlOne_reg, wData_reg, wStrb_reg, `C1_WMASK & 16'hFFFC);
        {1'b0, `ADDR_CTRL_TWO}:   ctrlTwo_reg   <= merge(ctrlTwo_reg, wData_reg, wStrb_reg, `C2_WMASK);
        {1'b0, `ADDR_CTRL_THREE}:
        begin
          if (!wStrb_reg[0] || wData_reg[7:0] <= `CONVERSION_CLOCK_DIVIDER_MAX)
            ctrlThree_reg <= merge(ctrlThree_reg, wData_reg, wStrb_reg, `C3_WMASK);
        end
        {1'b0, `ADDR_CHAN_SEL}:   chanSel_reg   <= merge(chanSel_reg, wData_reg, wStrb_reg, `CS_WMASK);
        `ADDR_SCAN_SEL:           scanSel_reg   <= merge(scanSel_reg, wData_reg, wStrb_reg, 16'hFFFF);
        default:                  ;
      endcase
    end
  end

  // ----------------------------------------
  // AXI read path
  // ----------------------------------------
  logic [15:0] rdWord;
  logic        rdOk;
  always_comb
  begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      {1'b0, `ADDR_CTRL_ONE}:   rdWord = {ctrlOne_reg[15:2], sample_active_reg, done_reg};
      {1'b0, `ADDR_CTRL_TWO}:   rdWord = {ctrlTwo_reg[15:8], buffer_fill_status_reg, ctrlTwo_reg[6:0]};
      {1'b0, `ADDR_CTRL_THREE}: rdWord = ctrlThree_reg;
      {1'b0, `ADDR_CHAN_SEL}:   rdWord = chanSel_reg;
      `ADDR_SCAN_SEL:           rdWord = scanSel_reg;
      `ADDR_STATUS:             rdWord = {12'h0, seqCnt_reg};
      default:
      begin
        rdWord = 16'h0;
        rdOk   = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0, rdWord};
      s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule : adc_sequencing_control
`default_nettype wire

// ==== verif/adc_sequencing_control_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module adc_sequencing_control_assertions #(
  parameter int CONV_PERIODS = 12,
  parameter int BUF_DEPTH    = 16
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        idleMode,
  input wire logic [15:0] resultData,
  input wire logic        converterActive,
  input wire logic        sampleHold,
  input wire logic        convertStart,
  input wire logic [1:0]  referenceSelect,
  input wire logic        convDoneEvent,
  input wire logic        sequenceInterrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------
  // Sequencing
  // ----------
  // Eight quiet cycles is safe: a conversion never lasts fewer clocks than that
  sequence convQuiet;
    (!convertStart && !convDoneEvent) [*8];
  endsequence
  sequence wasSampling;
    $past(sampleHold) || $past(sampleHold, 2);
  endsequence

  off_quiet_a: assert property (!converterActive |-> !convertStart && !convDoneEvent)
    else $error("Activity while converter inactive");
  start_gap_a: assert property (convertStart |=> convQuiet)
    else $error("Conversion ended too soon");
  trigger_ends_a: assert property (convertStart |-> wasSampling)
    else $error("Conversion started without sampling");
  done_bound_a: assert property (convertStart |-> ##[9:1000] convDoneEvent)
    else $error("Conversion never completed");
  irq_with_done_a: assert property (sequenceInterrupt |-> convDoneEvent || $past(convDoneEvent))
    else $error("Interrupt without result");
  lost_when_off_a: assert property ((!converterActive && !idleMode) [*2] |-> resultData == 16'h0000)
    else $error("Result readable while off");
  ref_write_a: assert property (!$stable(referenceSelect) |-> s_axi_bvalid)
    else $error("Reference moved without a write");

  // ----------
  // Register bus
  // ----------
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h14
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused");
endmodule : adc_sequencing_control_assertions

bind adc_sequencing_control adc_sequencing_control_assertions #(
  .CONV_PERIODS(CONV_PERIODS),
  .BUF_DEPTH(BUF_DEPTH)
) adc_sequencing_control_assertions_inst (
  .clk, .sys_rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_bvalid, .idleMode, .resultData, .converterActive, .sampleHold, .convertStart, .referenceSelect,
  .convDoneEvent, .sequenceInterrupt
);
`default_nettype wire

// ==== verif/adc_sequencing_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequencing_control_tb_top;
  logic        clk = 1'b0, sys_rst = 1'b1, rcClockTick = 1'b0, idleMode = 1'b0;
  logic        externalInterruptZero = 1'b0, timer3Compare = 1'b0, timer5Compare = 1'b0, chargeTimeUnitEvent = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00, positiveInputSel;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h3, resultIndex = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        converterActive, sampleHold, convertStart, negativeInputAlt, convDoneEvent, sequenceInterrupt;
  logic [1:0]  s_axi_bresp, s_axi_rresp, referenceSelect, rr, rcDiv = 2'h0;
  logic [9:0]  conversionData = 10'h2A5;
  logic [15:0] resultData;
  logic [2:0]  trg [6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h3, 3'h5};
  logic [15:0] fmtExp [4] = '{16'h02A5, 16'hFEA5, 16'hA940, 16'hA940};
  int          numErrors = 0, nCompared = 0, doneCnt = 0, irqCnt = 0, c0;

  adc_sequencing_control adc_sequencing_control_inst (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idleMode, .rcClockTick, .externalInterruptZero,
    .timer3Compare, .timer5Compare, .chargeTimeUnitEvent, .conversionData, .resultIndex, .resultData,
    .converterActive, .sampleHold, .convertStart, .positiveInputSel, .negativeInputAlt, .referenceSelect,
    .convDoneEvent, .sequenceInterrupt
  );

  always #10 clk = ~clk;

  // RC tick every fourth clock, so RC periods differ from the divider path
  always @(posedge clk)
  begin
    rcDiv <= rcDiv + 2'h1;
    rcClockTick <= (rcDiv == 2'h3);
    doneCnt <= doneCnt + int'(convDoneEvent);
    irqCnt <= irqCnt + int'(sequenceInterrupt);
  end

  // ----------
  // Bus tasks
  // ----------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Ready is judged at the falling edge, where the combinational answer has settled
  task automatic axi_wr(input logic [4:0] a, input logic [15:0] d);
    logic aw, w, fin;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      fin = s_axi_bvalid;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      if (fin)
        break;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, fin;
    ar = 1'b1;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      fin = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      ar = ar && !s_axi_arready;
      @(posedge clk);
      s_axi_arvalid <= ar;
      if (fin)
        break;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wr_rd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] e);
    axi_wr(a, d);
    axi_rd(a, rd, rr);
    check("regRead", rd, {16'h0000, e});
  endtask : wr_rd

  task automatic wait_done(input int n);
    int goal;
    goal = doneCnt + n;
    for (int t = 0; t < 4000 && doneCnt < goal; t++)
      @(posedge clk);
    check("doneCount", doneCnt, goal);
  endtask : wait_done

  task automatic fire(input logic [2:0] c);
    @(posedge clk);
    externalInterruptZero <= (c == 3'h1);
    timer3Compare <= (c == 3'h2);
    timer5Compare <= (c == 3'h4);
    chargeTimeUnitEvent <= (c == 3'h6);
    @(posedge clk);
    {externalInterruptZero, timer3Compare, timer5Compare, chargeTimeUnitEvent} <= 4'h0;
  endtask : fire

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // ----------
  // Tests
  // ----------
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++)
    begin
      axi_rd(5'(a * 4), rd, rr);
      check("resetRead", rd, 32'h0);
      check("readResp", rr, (a == 6) ? 2'h2 : 2'h0);
    end
    wr_rd(`ADDR_CTRL_ONE, 16'h5C18, 16'h0000);
    wr_rd(`ADDR_CTRL_TWO, 16'hFFFF, 16'hE43F);
    wr_rd(`ADDR_CTRL_THREE, 16'h9F3F, 16'h9F3F);
    wr_rd(`ADDR_CTRL_THREE, 16'h0040, 16'h9F3F);
    wr_rd(`ADDR_CHAN_SEL, 16'hFFFF, 16'h9F9F);
    for (int c = 0; c < 8; c++)
    begin
      axi_wr(`ADDR_CTRL_TWO, 16'(c << 13));
      check("refSel", referenceSelect, c[2] ? 2'h0 : 2'(c));
    end
    axi_wr(`ADDR_CHAN_SEL, 16'h0A91);
    check("posSel", positiveInputSel, 5'h11);
    check("negAlt", negativeInputAlt, 1'b1);
    axi_wr(`ADDR_CTRL_TWO, 16'h000C);
    axi_wr(`ADDR_CTRL_THREE, 16'h0000);
    for (int f = 0; f < 4; f++)
    begin
      axi_wr(`ADDR_CTRL_ONE, 16'h8002 | 16'(f << 8));
      check("sampling", sampleHold, 1'b1);
      axi_wr(`ADDR_CTRL_ONE, 16'h8000 | 16'(f << 8));
      wait_done(1);
      axi_rd(`ADDR_CTRL_ONE, rd, rr);
      check("doneBits", rd[1:0], 2'h1);
      resultIndex <= 4'(f);
      repeat (2) @(posedge clk);
      check("result", resultData, fmtExp[f]);
    end
    check("irqCount", irqCnt, 32'h1);
    idleMode <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      axi_wr(`ADDR_CTRL_ONE, 16'h8002 | (16'(trg[k]) << 5));
      check("activeIdle", converterActive, 1'b1);
      c0 = doneCnt;
      for (int j = 0; j < 4; j++)
        if (trg[j] != trg[k])
          fire(trg[j]);
      repeat (20) @(posedge clk);
      check("strayTrigger", doneCnt, c0);
      if (k < 4)
      begin
        fire(trg[k]);
        wait_done(1);
      end
    end
    idleMode <= 1'b0;
    axi_wr(`ADDR_CTRL_THREE, 16'h8300);
    axi_wr(`ADDR_CTRL_TWO, 16'h0008);
    c0 = irqCnt;
    axi_wr(`ADDR_CTRL_ONE, 16'hA0E6);
    wait_done(9);
    repeat (2) @(posedge clk);
    check("irqCount", irqCnt - c0, 32'h3);
    idleMode <= 1'b1;
    repeat (3) @(posedge clk);
    c0 = doneCnt;
    check("activeHalt", converterActive, 1'b0);
    repeat (200) @(posedge clk);
    check("haltedDone", doneCnt, c0);
    idleMode <= 1'b0;
    wait_done(1);
    axi_wr(`ADDR_CTRL_ONE, 16'h0000);
    c0 = doneCnt;
    resultIndex <= 4'h0;
    repeat (100) @(posedge clk);
    check("activeOff", converterActive, 1'b0);
    check("offDone", doneCnt, c0);
    check("resultOff", resultData, 16'h0000);
    axi_wr(`ADDR_CTRL_THREE, 16'h0000);
    axi_wr(`ADDR_SCAN_SEL, 16'h0050);
    axi_wr(`ADDR_CHAN_SEL, 16'h0305);
    axi_wr(`ADDR_CTRL_TWO, 16'h0403);
    for (int s = 0; s < 3; s++)
    begin
      check("muxSel", positiveInputSel, (s == 1) ? 5'h03 : 5'(4 + s));
      axi_rd(`ADDR_CTRL_TWO, rd, rr);
      check("fillHalf", rd[7], s[0]);
      axi_wr(`ADDR_CTRL_ONE, 16'h8002);
      axi_wr(`ADDR_CTRL_ONE, 16'h8000);
      wait_done(1);
    end
    resultIndex <= 4'h8;
    repeat (2) @(posedge clk);
    check("upperHalf", resultData, 16'h02A5);
    tally_and_finish();
  end

  // Whole run needs well under ten thousand clocks
  initial
  begin
    repeat (50000) @(posedge clk);
    numErrors++;
    tally_and_finish();
  end
endmodule : adc_sequencing_control_tb_top
`default_nettype wire
